/* inc/spi_cmd_regs.svh */
// Constants for the serial command front end.
// Assumes inclusion by bare name from the package file.
`ifndef SPI_CMD_REGS_SVH
`define SPI_CMD_REGS_SVH

// Bit counts within a frame
`define SC_ADDR_BITS   4'h2
`define SC_CMD_BITS    4'h8
`define SC_LAST_CMD    4'h7
`define SC_CNT_MAX     4'hF
`define SC_CNT_WRAP    4'h8

// Command byte fields
`define SC_ADDR_MSB    7
`define SC_ADDR_LSB    6
`define SC_CODE_MSB    5
`define SC_CODE_LSB    2
`define SC_TYPE_MSB    1
`define SC_TYPE_LSB    0

// Quick operation codes
`define SC_QO_START    4'hA
`define SC_QO_STANDBY  4'hB
`define SC_QO_CONV_OFF 4'hC
`define SC_QO_FULL_OFF 4'hD
`define SC_QO_RESET    4'hE

// Run state values written by quick operations
`define SC_RUN_START   2'h3
`define SC_RUN_STANDBY 2'h2
`define SC_RUN_OFF     2'h0
`define SC_RUN_RST     2'h0

// Read-only register addresses
`define SC_RO_ADDR_LO  4'h0
`define SC_RO_ADDR_HI  4'hF

// Status flag positions
`define SC_FLAG_READY  2
`define SC_FLAG_CHECK  1
`define SC_FLAG_POR    0

`endif

/* inc/spi_cmd_pkg.sv */
// Types shared by the serial command front end.
// Assumes the constants header is on the include path.
`include "spi_cmd_regs.svh"

package spi_cmd_pkg;

  typedef enum logic [1:0]
  {
    CT_QUICK     = 2'b00,
    CT_STATIC_RD = 2'b01,
    CT_INC_WR    = 2'b10,
    CT_INC_RD    = 2'b11
  } cmd_type_t;

  typedef enum logic [2:0]
  {
    QO_NONE      = 3'b000,
    QO_START     = 3'b001,
    QO_STANDBY   = 3'b010,
    QO_CONV_OFF  = 3'b011,
    QO_FULL_OFF  = 3'b100,
    QO_RESET     = 3'b101
  } quick_op_t;

  typedef enum logic [1:0]
  {
    PH_IDLE   = 2'b00,
    PH_CMD    = 2'b01,
    PH_DATA   = 2'b10,
    PH_IGNORE = 2'b11
  } phase_t;

endpackage

/* design/spi_command_front_end.sv */
// Serial target front end: command byte decode, status byte, quick operations.
// Assumes pins cs_n_i, sck_i, sdi_i are asynchronous to clk_i and that the
// serial clock runs well below a quarter of clk_i.
//
// Behaviour
// - A frame runs from chip select low to chip select high, each independent.
// - First eight serial input bits after select falls form the command byte.
// - Command splits into chip address, code, and command type fields.
// - Chip address is a fixed two-bit value caught after reset.
// - Foreign chip address: command ignored, output released after the top two status bits.
// - Type 01 static read, 10 write, 11 read, 00 quick operation.
// - Command type holds for the whole frame.
// - Codes 1010, 1011, 1100 set run state to 11, 10, 00.
// - Code 1101 clears the first configuration register.
// - Code 1110 resets everything; power-on flag then reads one.
// - Undefined quick codes have no effect.
// - Quick operation runs after the command byte; output released afterwards.
// - Quick operations only run while quick operation enable is set.
// - Writes to read-only registers are not executed.
// - Status byte shifts out while the command byte shifts in.
// - Top two status bits zero; output driven low as select falls.
// - Status bits 5..3 carry chip address and inverted address bit zero.
// - Status bits 2..0 carry ready, check error, power-on flags.
// - Status flags are cleared once a full status byte is sent.
// - Flags captured on address match; later events go to next frame.
// - After status, output released except for reads which stream data.
// - Input sampled on rising serial clock, output changes on falling.
// - Select rising abandons the frame and restarts the interface.
`timescale 1ns/1ps

module spi_command_front_end
  import spi_cmd_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // Serial pins
  input  wire logic              cs_n_i,
  input  wire logic              sck_i,
  input  wire logic              sdi_i,
  output logic                   sdo_o,
  output logic                   sdo_oe_o,
  // Configuration
  input  wire logic [1:0]        chip_address_code_i,
  input  wire logic              quick_op_enable_i,
  // Flag events
  input  wire logic              sample_ready_evt_i,
  input  wire logic              config_check_error_evt_i,
  // Register side
  input  wire logic [DATA_W-1:0] rd_data_i,
  output logic                   rd_take_o,
  output logic                   cmd_valid_o,
  output logic [1:0]             cmd_type_o,
  output logic [3:0]             cmd_addr_o,
  output logic                   wr_refused_o,
  // Converter control
  output logic [1:0]             run_state_o,
  output logic                   run_state_wr_o,
  output logic                   config_clear_o,
  output logic                   full_reset_o,
  output logic [2:0]             status_flags_o
);

  generate
    if (DATA_W != 8)
    begin : g_check
      $error("DATA_W must be 8");
    end
  endgenerate

  function automatic quick_op_t quick_decode(input logic [3:0] code);
    quick_op_t op;
    op = QO_NONE;
    unique case (code)
      `SC_QO_START:    op = QO_START;
      `SC_QO_STANDBY:  op = QO_STANDBY;
      `SC_QO_CONV_OFF: op = QO_CONV_OFF;
      `SC_QO_FULL_OFF: op = QO_FULL_OFF;
      `SC_QO_RESET:    op = QO_RESET;
      default:         op = QO_NONE;
    endcase
    return op;
  endfunction

  function automatic logic is_read(input logic [1:0] ct);
    return ct == CT_STATIC_RD || ct == CT_INC_RD;
  endfunction

  // Pin synchronisers
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic       sck_d_reg;
  wire  [2:0] pin_raw = {cs_n_i, sck_i, sdi_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          pin_s1_reg[gi] <= (gi == 2) ? 1'b1 : 1'b0;
          pin_s2_reg[gi] <= (gi == 2) ? 1'b1 : 1'b0;
        end
        else
        begin
          pin_s1_reg[gi] <= pin_raw[gi];
          pin_s2_reg[gi] <= pin_s1_reg[gi];
        end
      end
    end
  endgenerate

  wire cs_low   = ~pin_s2_reg[2];
  wire sck_s    = pin_s2_reg[1];
  wire sdi_s    = pin_s2_reg[0];
  wire sck_rise = sck_s & ~sck_d_reg;
  wire sck_fall = ~sck_s & sck_d_reg;

  // Frame state
  phase_t      phase_reg, phase_next;
  logic [3:0]  bit_cnt_reg;
  logic [3:0]  out_idx_reg;
  logic [6:0]  cmd_sr_reg;
  logic [1:0]  type_reg;
  logic [2:0]  snap_reg;
  logic [DATA_W-1:0] rd_sr_reg;
  logic [1:0]  addr_reg;
  logic        addr_taken_reg;
  logic [2:0]  flag_reg, flag_next;

  wire [3:0] bit_cnt_next = (bit_cnt_reg == `SC_CNT_MAX) ? `SC_CNT_WRAP
                                                        : bit_cnt_reg + 4'h1;
  wire [7:0] cmd_word     = {cmd_sr_reg, sdi_s};
  wire [1:0] cmd_chip     = cmd_word[1:0];      // Address bits as seen at the second rise
  wire [3:0] cmd_code     = cmd_word[`SC_CODE_MSB:`SC_CODE_LSB];
  wire [1:0] cmd_type     = cmd_word[`SC_TYPE_MSB:`SC_TYPE_LSB];
  wire       in_cmd_rise  = sck_rise && phase_reg == PH_CMD;
  wire       addr_check   = in_cmd_rise && bit_cnt_next == `SC_ADDR_BITS;
  wire       addr_hit     = addr_check && cmd_chip == addr_reg;
  wire       addr_miss    = addr_check && cmd_chip != addr_reg;
  wire       cmd_done     = in_cmd_rise && bit_cnt_reg == `SC_LAST_CMD;
  wire       status_done  = cmd_done;
  wire       ro_addr      = cmd_code == `SC_RO_ADDR_LO || cmd_code == `SC_RO_ADDR_HI;
  wire       is_write     = cmd_type == CT_INC_WR;
  wire       quick_type   = cmd_type == CT_QUICK;
  quick_op_t quick_op;
  assign quick_op = quick_decode(cmd_code);
  wire       quick_exec   = cmd_done && quick_type && quick_op_enable_i
                            && quick_op != QO_NONE;
  wire       rd_frame     = phase_reg == PH_DATA && is_read(type_reg);
  wire       byte_start   = sck_fall && bit_cnt_reg >= `SC_CMD_BITS
                            && bit_cnt_reg[2:0] == 3'h0;

  // Phase sequencing
  always_comb
  begin
    phase_next = phase_reg;
    unique case (phase_reg)
      PH_IDLE:   if (cs_low) phase_next = PH_CMD;
      PH_CMD:
      begin
        if (addr_miss) phase_next = PH_IGNORE;
        else if (cmd_done) phase_next = PH_DATA;
      end
      PH_DATA:   phase_next = PH_DATA;
      PH_IGNORE: phase_next = PH_IGNORE;
    endcase
    if (!cs_low) phase_next = PH_IDLE;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phase_reg   <= PH_IDLE;
      bit_cnt_reg <= 4'h0;
      out_idx_reg <= 4'h0;
      cmd_sr_reg  <= 7'h00;
      sck_d_reg   <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      sck_d_reg <= sck_s;
      if (!cs_low)
      begin
        bit_cnt_reg <= 4'h0;
        out_idx_reg <= 4'h0;
      end
      else
      begin
        if (sck_rise) bit_cnt_reg <= bit_cnt_next;
        if (sck_rise) cmd_sr_reg <= cmd_word[6:0];
        if (sck_fall) out_idx_reg <= bit_cnt_reg;
      end
    end
  end

  // Chip address strap, caught after reset release
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      addr_reg       <= 2'h0;
      addr_taken_reg <= 1'b0;
    end
    else if (!addr_taken_reg)
    begin
      addr_reg       <= chip_address_code_i;
      addr_taken_reg <= 1'b1;
    end
  end

  // Status flags: set wins over clear, status byte clears only captured bits, full reset clears all then sets power-on
  always_comb
  begin
    flag_next = flag_reg;
    if (status_done) flag_next = flag_reg & ~snap_reg;
    if (quick_exec && quick_op == QO_RESET)
      flag_next = 3'h0;
    flag_next[`SC_FLAG_READY] = flag_next[`SC_FLAG_READY] | sample_ready_evt_i;
    flag_next[`SC_FLAG_CHECK] = flag_next[`SC_FLAG_CHECK] | config_check_error_evt_i;
    if (quick_exec && quick_op == QO_RESET)
      flag_next[`SC_FLAG_POR] = 1'b1;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      flag_reg <= 3'h0;
      snap_reg <= 3'h0;
      type_reg <= 2'h0;
    end
    else
    begin
      flag_reg <= flag_next;
      if (addr_hit) snap_reg <= flag_reg;
      if (cmd_done) type_reg <= cmd_type;
    end
  end

  // Serial output
  wire [7:0] status_byte = {2'b00, addr_reg, ~addr_reg[0], snap_reg};
  wire       in_status   = out_idx_reg < `SC_CMD_BITS;
  wire       frame_on    = cs_low && phase_reg != PH_IDLE;
  wire       sdo_next    = in_status ? status_byte[3'h7 - out_idx_reg[2:0]]
                                     : rd_sr_reg[DATA_W-1];
  wire       oe_next     = frame_on && (out_idx_reg < `SC_ADDR_BITS
                           || (phase_reg != PH_IGNORE
                               && (in_status || rd_frame)));

  assign rd_take_o = byte_start && rd_frame;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sdo_o     <= 1'b0;
      sdo_oe_o  <= 1'b0;
      rd_sr_reg <= '0;
    end
    else
    begin
      sdo_o    <= sdo_next;
      sdo_oe_o <= oe_next;
      if (rd_take_o) rd_sr_reg <= rd_data_i;
      else if (sck_fall) rd_sr_reg <= {rd_sr_reg[DATA_W-2:0], 1'b0};
    end
  end

  // Command hand-off and quick operations
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cmd_valid_o    <= 1'b0;
      cmd_type_o     <= 2'h0;
      cmd_addr_o     <= 4'h0;
      wr_refused_o   <= 1'b0;
      run_state_o    <= `SC_RUN_RST;
      run_state_wr_o <= 1'b0;
      config_clear_o <= 1'b0;
      full_reset_o   <= 1'b0;
    end
    else
    begin
      cmd_valid_o    <= cmd_done && !quick_type && !(is_write && ro_addr);
      wr_refused_o   <= cmd_done && is_write && ro_addr;
      run_state_wr_o <= 1'b0;
      config_clear_o <= 1'b0;
      full_reset_o   <= 1'b0;
      if (cmd_done)
      begin
        cmd_type_o <= cmd_type;
        cmd_addr_o <= cmd_code;
      end
      if (quick_exec)
      begin
        unique case (quick_op)
          QO_START:    run_state_o <= `SC_RUN_START;
          QO_STANDBY:  run_state_o <= `SC_RUN_STANDBY;
          QO_CONV_OFF: run_state_o <= `SC_RUN_OFF;
          QO_FULL_OFF: config_clear_o <= 1'b1;
          QO_RESET:    run_state_o <= `SC_RUN_RST;
          default:     run_state_o <= run_state_o;
        endcase
        run_state_wr_o <= quick_op inside {QO_START, QO_STANDBY, QO_CONV_OFF};
        full_reset_o   <= quick_op == QO_RESET;
      end
    end
  end

  assign status_flags_o = flag_reg;

  // Checks
  a_idle_released: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !cs_low |=> ##1 !sdo_oe_o)
    else $error("output driven outside a frame");

  a_miss_released: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (phase_reg == PH_IGNORE && out_idx_reg >= `SC_ADDR_BITS) |=> !sdo_oe_o)
    else $error("output driven after address mismatch");

  a_lead_bits_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (frame_on && out_idx_reg < `SC_ADDR_BITS) |=> (sdo_oe_o && !sdo_o))
    else $error("leading status bits not driven low");

  a_ack_toggle: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (phase_reg == PH_CMD && out_idx_reg == 4'h4)
      |=> (sdo_oe_o && sdo_o == !addr_reg[0]))
    else $error("acknowledge bit wrong");

  a_quick_enable: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (run_state_wr_o || config_clear_o || full_reset_o) |-> $past(quick_op_enable_i))
    else $error("quick operation ran while disabled");

  a_quick_codes: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cmd_done && quick_type && quick_op == QO_NONE |=> !(run_state_wr_o
      || config_clear_o || full_reset_o))
    else $error("undefined quick code had an effect");

  a_por_after_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
    full_reset_o |-> flag_reg[`SC_FLAG_POR] && run_state_o == `SC_RUN_RST)
    else $error("power-on flag not set by full reset");

  a_quick_released: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (phase_reg == PH_DATA && type_reg == CT_QUICK && !in_status) |=> !sdo_oe_o)
    else $error("output driven after quick command");

  a_flag_cleared: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (status_done && snap_reg[`SC_FLAG_READY] && !sample_ready_evt_i)
      |=> !flag_reg[`SC_FLAG_READY])
    else $error("captured flag not cleared");

  c_match:    cover property (@(posedge clk_i) addr_hit);
  c_mismatch: cover property (@(posedge clk_i) addr_miss);
  c_quick:    cover property (@(posedge clk_i) quick_exec);
  c_read:     cover property (@(posedge clk_i) rd_take_o);

endmodule

/* bench/spi_host_model.sv */
// Serial host model: frames command bytes and captures the returned bits.
// Assumes the bench resolves the data-out wire and seeds the random source.
`timescale 1ns/1ps

module spi_host_model
(
  // Serial pins
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  localparam time HALF = 80ns;

  initial
  begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    sdi_o  = 1'b0;
  end

  // One framed transfer of nb bits, MSB first; cpol is the idle clock level
  task automatic frame(input logic [7:0] cmd, input int nb, input bit cpol,
                       output logic [31:0] rx);
    logic [31:0] tx;
    tx = {cmd, 24'h0} | ($urandom() & 32'h00FFFFFF);
    rx = '0;
    sck_o = cpol;
    #(HALF);
    cs_n_o = 1'b0;
    #(HALF);
    for (int i = 0; i < nb; i++)
    begin
      sck_o = 1'b0;
      sdi_o = tx[31-i];
      #(HALF);
      sck_o = 1'b1;
      rx = {rx[30:0], sdo_i};
      #(HALF);
    end
    sck_o = cpol;
    #(HALF);
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask
endmodule

/* bench/spi_command_front_end_tb_top.sv */
// Self-checking bench for the serial command front end.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/1ps

module spi_command_front_end_tb_top;
  import spi_cmd_pkg::*;

  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  wire logic   cs_n, sck, sdi, sdo, sdo_oe, sdo_line;
  logic [1:0]  strap = 2'h0;
  logic        en = 1'b1;
  logic        rdy_evt = 1'b0;
  logic        chk_evt = 1'b0;
  logic [7:0]  rd = 8'h00;
  logic        rd_take, cmd_valid, wr_refused, rs_wr, cfg_clr, full_rst;
  logic [1:0]  cmd_type, run_state;
  logic [3:0]  cmd_addr;
  logic [2:0]  status_flags;
  logic [2:0]  flags = 3'h0;
  logic [1:0]  rs = 2'h0;
  logic [25:0] q[$];
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          n_take = 0;
  int          seed_val;

  localparam logic [12:0] M_Q = 13'h1F81;
  wire logic [12:0] ev_got = {rs_wr, run_state, cfg_clr, full_rst, cmd_valid,
                              cmd_type, cmd_addr, wr_refused};
  wire logic ev_seen = rs_wr | cfg_clr | full_rst | cmd_valid | wr_refused;
  assign sdo_line = sdo_oe ? sdo : 1'bz;

  always #5 clk_i = ~clk_i;

  spi_host_model spi_host_model_inst (.cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi),
                                      .sdo_i(sdo_line));

  spi_command_front_end spi_command_front_end_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .sck_i(sck), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .chip_address_code_i(strap),
    .quick_op_enable_i(en), .sample_ready_evt_i(rdy_evt),
    .config_check_error_evt_i(chk_evt), .rd_data_i(rd), .rd_take_o(rd_take),
    .cmd_valid_o(cmd_valid), .cmd_type_o(cmd_type), .cmd_addr_o(cmd_addr),
    .wr_refused_o(wr_refused), .run_state_o(run_state), .run_state_wr_o(rs_wr),
    .config_clear_o(cfg_clr), .full_reset_o(full_rst), .status_flags_o(status_flags));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t serial byte %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cmp_evt(input logic [12:0] got);
    logic [25:0] n;
    total_checks++;
    if (q.size() == 0)
    begin
      n_mismatch++;
      $display("ERROR %0t unexpected event %b", $time, got);
    end
    else
    begin
      n = q.pop_front();
      if ((got & n[25:13]) !== (n[12:0] & n[25:13]))
      begin
        n_mismatch++;
        $display("ERROR %0t event %b expected %b", $time, got, n[12:0]);
      end
    end
  endtask

  // Result watcher: each output pulse except rd_take consumes the oldest note
  always @(posedge clk_i)
  begin
    cycles++;
    if (resetn_i === 1'b1 && ev_seen === 1'b1)
      cmp_evt(ev_got);
    if (resetn_i === 1'b1 && rd_take === 1'b1)
      n_take++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic quick_exp(input logic [3:0] c);
    if (c == 4'hA || c == 4'hB || c == 4'hC)
    begin
      rs = (c == 4'hA) ? 2'h3 : (c == 4'hB) ? 2'h2 : 2'h0;
      q.push_back({M_Q, 1'b1, rs, 10'h000});
    end
    else if (c == 4'hD)
      q.push_back({M_Q, 1'b0, rs, 1'b1, 9'h000});
    else if (c == 4'hE)
    begin
      rs = 2'h0;
      q.push_back({M_Q, 13'h0100});
    end
  endtask

  task automatic do_frame(input logic [1:0] a, input logic [3:0] c, input logic [1:0] t,
                          input int nb, input bit cpol);
    logic [31:0] rx;
    logic [7:0]  st;
    logic        match;
    match = (a == strap);
    st = match ? {2'b00, a, ~a[0], flags} : 8'b00ZZZZZZ;
    if (match && nb >= 8)
    begin
      if (t == 2'b00 && en)
        quick_exp(c);
      else if (t == 2'b10 && (c == 4'h0 || c == 4'hF))
        q.push_back({13'h1FFF, 1'b0, rs, 3'b000, t, c, 1'b1});
      else if (t != 2'b00)
        q.push_back({13'h1FFF, 1'b0, rs, 3'b001, t, c, 1'b0});
    end
    n_take = 0;
    spi_host_model_inst.frame({a, c, t}, nb, cpol, rx);
    if (nb >= 8)
      cmp_byte(rx[nb-1 -: 8], st);
    for (int i = 16; i <= nb; i += 8)
      cmp_byte(rx[nb-i+7 -: 8], (match && t[0]) ? rd : 8'hZZ);
    if (match && nb >= 8)
      flags = (t == 2'b00 && en && c == 4'hE) ? 3'b001 : 3'b000;
    #200ns;
    cmp_byte(8'(n_take), (match && t[0] && nb >= 8) ? 8'(nb / 8) : 8'h00);
  endtask

  task automatic pulse_evt(input bit ready);
    @(posedge clk_i);
    #1;
    rdy_evt = ready;
    chk_evt = ~ready;
    @(posedge clk_i);
    #1;
    rdy_evt = 1'b0;
    chk_evt = 1'b0;
  endtask

  initial
  begin
    seed_val = $urandom(32'hDE5EBFCF);
    strap = 2'($urandom());
    repeat (20) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    for (int c = 0; c < 16; c++)
      do_frame(strap, 4'(c), 2'b00, 16, 1'b0);
    en = 1'b0;
    do_frame(strap, 4'hA, 2'b00, 8, 1'b0);
    en = 1'b1;
    do_frame(strap, 4'hA, 2'b00, 8, 1'b1);
    for (int k = 1; k < 4; k++)
      do_frame(strap ^ 2'(k), 4'h5, 2'b11, 16, 1'b0);
    do_frame(strap, 4'h0, 2'b10, 16, 1'b0);
    do_frame(strap, 4'hF, 2'b10, 16, 1'b0);
    do_frame(strap, 4'h5, 2'b10, 16, 1'b0);
    rd = 8'($urandom());
    do_frame(strap, 4'($urandom()), 2'b11, 24, 1'b0);
    do_frame(strap, 4'($urandom()), 2'b01, 24, 1'b0);
    pulse_evt(1'b1);
    pulse_evt(1'b0);
    flags = 3'b110;
    cmp_byte({5'h00, status_flags}, {5'h00, flags});
    do_frame(strap, 4'h3, 2'b01, 16, 1'b0);
    fork
      do_frame(strap, 4'h3, 2'b01, 16, 1'b0);
      begin
        #800ns;
        pulse_evt(1'b1);
      end
    join
    flags = 3'b100;
    cmp_byte({5'h00, status_flags}, {5'h00, flags});
    do_frame(strap, 4'h4, 2'b11, 16, 1'b0);
    do_frame(strap, 4'hA, 2'b00, 5, 1'b0);
    do_frame(strap, 4'hC, 2'b00, 8, 1'b0);
    repeat (10) @(posedge clk_i);
    if (q.size() != 0)
    begin
      n_mismatch++;
      $display("ERROR %0t %0d events missing", $time, q.size());
    end
    complete_run();
  end
endmodule
